/* File: hdl/dgc_pkg.sv */
// Purpose: Shared constants and types for the disk gate and clock glue block
// Assumes: Link clock runs at twice the drive bit rate, one cycle per half bit
// Notes:   All link timing counts are in half-bit cycles
package dgc_pkg;

	// Operation requested by the core side
	typedef enum logic [1:0] {
		DGC_OP_READ,
		DGC_OP_WRITE,
		DGC_OP_FORMAT
	} dgc_op_e;

	// Link-side sequencer states
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_WAIT,
		LS_LEAD,
		LS_HDR,
		LS_POST,
		LS_SPLICE,
		LS_DATA,
		LS_FMT
	} dgc_link_st_e;

	localparam int unsigned HALF_PER_BYTE   = 16;   // Eight bits of two half bits
	localparam int unsigned SOS_LEAD_HALF   = 7;    // 3.5 bit times after the pulse
	localparam int unsigned SPLICE_WG_HALF  = 6;    // 3 bit times into the preamble
	localparam int unsigned HDR_POST_BYTES  = 2;    // Header postamble length
	localparam int unsigned SPLICE_BYTES    = 1;    // Floating splice byte
	localparam int unsigned CNT_W           = 16;

	// Core-side state
	typedef struct packed {
		logic    ack1;
		logic    ack2;
		logic    ack_seen;
		logic    req;
		dgc_op_e op;
		logic    busy;
		logic    done;
	} dgc_core_s;

	// Link-side state
	typedef struct packed {
		logic             rs1;
		logic             rs2;
		logic             idx1;
		logic             idx2;
		logic             idx3;
		logic             sec1;
		logic             sec2;
		logic             sec3;
		logic             req1;
		logic             req2;
		logic             req_seen;
		logic             ack;
		dgc_op_e          op;
		dgc_link_st_e     st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] gcnt;
		logic             rg;
		logic             wg;
		logic             gap;
	} dgc_link_s;

	localparam dgc_core_s CORE_RST = '{op: DGC_OP_READ, default: 1'b0};

endpackage

/* File: hdl/dgc_gate_seq.sv */
// Purpose: Read gate, write gate and gap-fill sequencing for one sector or track
// Assumes: LINK_CLK_I is twice the bit rate; index and sector pulses are asynchronous
// Notes:   Core side starts an operation and sees busy and a done pulse
//
// Behaviour
// - This block holds write gate low through the ID field and the header postamble.
// - Format raises write gate 3.5 bit times after index only; sector pulses restart the gap fill.
// - Format write gate stays up the whole track until the next index.
// - Write counts floating byte as preamble; write gate 3 bit times into it.
// - Read counts floating byte as postamble; read gate never in the splice.
// - The gap pattern is also written into the post-index gap field.
// - Read gate starts 3.5 bit times after the pulse; in a write, write gate rises later, in the splice byte.
`timescale 1ns/1ps
module dgc_gate_seq #(
	parameter int unsigned HDR_BYTES  = 6,    // ID field including check bytes
	parameter int unsigned PRE_BYTES  = 12,   // Data preamble including floating byte
	parameter int unsigned DATA_BYTES = 518,  // Data field including check bytes
	parameter int unsigned GAP_BYTES  = 16    // Post-index gap field
) (
	input  wire logic            CORE_CLK_I,
	input  wire logic            RST_N_I,
	input  wire logic            LINK_CLK_I,
	input  wire logic            CMD_START_I,
	input  wire dgc_pkg::dgc_op_e CMD_OP_I,
	input  wire logic            INDEX_I,
	input  wire logic            SECTOR_I,
	output logic                 BUSY_O,
	output logic                 DONE_O,
	output logic                 READ_GATE_O,
	output logic                 WRITE_GATE_O,
	output logic                 GAP_FILL_O
);

	localparam int unsigned W = dgc_pkg::CNT_W;

	// Counts must fit the counter; an oversize field would wrap silently
	if ((PRE_BYTES + DATA_BYTES) * dgc_pkg::HALF_PER_BYTE >= (1 << W) ||
	    HDR_BYTES == 0 || DATA_BYTES == 0 || GAP_BYTES == 0 ||
	    PRE_BYTES <= dgc_pkg::SPLICE_BYTES) begin : g_chk
		$error("dgc_gate_seq: field lengths out of range");
	end

	// Byte count to a half-bit counter load value, one less than the length
	function automatic logic [W-1:0] half_load(input int unsigned bytes, input int unsigned extra);
		half_load = W'(bytes * dgc_pkg::HALF_PER_BYTE + extra - 1);
	endfunction

	dgc_pkg::dgc_core_s c;
	dgc_pkg::dgc_core_s next_c;
	dgc_pkg::dgc_link_s l;
	dgc_pkg::dgc_link_s next_l;

	// Core side: accept a command, toggle the request, watch the returned ack
	always_comb begin
		next_c = c;
		next_c.ack1 = l.ack;
		next_c.ack2 = c.ack1;
		next_c.done = 1'b0;
		if (CMD_START_I && !c.busy) begin
			next_c.req  = ~c.req;
			next_c.op   = CMD_OP_I;
			next_c.busy = 1'b1;
		end
		if (c.ack2 != c.ack_seen) begin
			next_c.ack_seen = c.ack2;
			next_c.busy     = 1'b0;
			next_c.done     = 1'b1;
		end
		if (!RST_N_I) begin
			next_c = dgc_pkg::CORE_RST;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		c <= next_c;
	end

	logic idx_edge;
	logic sec_edge;
	assign idx_edge = l.idx2 & ~l.idx3;
	assign sec_edge = l.sec2 & ~l.sec3;

	// Link side sequencer; reset reaches this domain through two flops.
	// The op register is stable while the request toggle is in flight.
	always_comb begin
		next_l = l;
		next_l.rs1  = RST_N_I;
		next_l.rs2  = l.rs1;
		next_l.idx1 = INDEX_I;
		next_l.idx2 = l.idx1;
		next_l.idx3 = l.idx2;
		next_l.sec1 = SECTOR_I;
		next_l.sec2 = l.sec1;
		next_l.sec3 = l.sec2;
		next_l.req1 = c.req;
		next_l.req2 = l.req1;
		if (l.cnt != '0) begin
			next_l.cnt = l.cnt - W'(1);
		end
		// Gap field runs under write gate after each pulse in format
		if (l.gcnt != '0) begin
			next_l.gcnt = l.gcnt - W'(1);
		end else begin
			next_l.gap = 1'b0;
		end
		case (l.st)
			dgc_pkg::LS_IDLE: begin
				if (l.req2 != l.req_seen) begin
					next_l.req_seen = l.req2;
					next_l.op       = c.op;
					next_l.st       = dgc_pkg::LS_WAIT;
				end
			end
			dgc_pkg::LS_WAIT: begin
				// Format starts on index only; reads and writes on any pulse
				if (idx_edge || (sec_edge && l.op != dgc_pkg::DGC_OP_FORMAT)) begin
					next_l.st  = dgc_pkg::LS_LEAD;
					next_l.cnt = W'(dgc_pkg::SOS_LEAD_HALF - 2);
				end
			end
			dgc_pkg::LS_LEAD: begin
				if (l.cnt == '0) begin
					if (l.op == dgc_pkg::DGC_OP_FORMAT) begin
						next_l.wg   = 1'b1;
						next_l.gap  = 1'b1;
						next_l.gcnt = half_load(GAP_BYTES, 0);
						next_l.st   = dgc_pkg::LS_FMT;
					end else begin
						next_l.rg  = 1'b1;
						next_l.cnt = half_load(HDR_BYTES, 0);
						next_l.st  = dgc_pkg::LS_HDR;
					end
				end
			end
			dgc_pkg::LS_HDR: begin
				if (l.cnt == '0) begin
					next_l.rg = 1'b0;
					next_l.st = dgc_pkg::LS_POST;
					// Reads hold off through the floating byte as well
					if (l.op == dgc_pkg::DGC_OP_READ) begin
						next_l.cnt = half_load(dgc_pkg::HDR_POST_BYTES
						                       + dgc_pkg::SPLICE_BYTES, 0);
					end else begin
						next_l.cnt = half_load(dgc_pkg::HDR_POST_BYTES, 0);
					end
				end
			end
			dgc_pkg::LS_POST: begin
				if (l.cnt == '0) begin
					if (l.op == dgc_pkg::DGC_OP_READ) begin
						next_l.rg  = 1'b1;
						next_l.cnt = half_load(PRE_BYTES - dgc_pkg::SPLICE_BYTES
						                       + DATA_BYTES, 0);
						next_l.st  = dgc_pkg::LS_DATA;
					end else begin
						next_l.cnt = W'(dgc_pkg::SPLICE_WG_HALF - 1);
						next_l.st  = dgc_pkg::LS_SPLICE;
					end
				end
			end
			dgc_pkg::LS_SPLICE: begin
				// Write gate rises inside the floating byte, never earlier
				if (l.cnt == '0) begin
					next_l.wg  = 1'b1;
					next_l.cnt = half_load(PRE_BYTES + DATA_BYTES,
					                       0) - W'(dgc_pkg::SPLICE_WG_HALF);
					next_l.st  = dgc_pkg::LS_DATA;
				end
			end
			dgc_pkg::LS_DATA: begin
				if (l.cnt == '0) begin
					next_l.rg  = 1'b0;
					next_l.wg  = 1'b0;
					next_l.ack = ~l.ack;
					next_l.st  = dgc_pkg::LS_IDLE;
				end
			end
			dgc_pkg::LS_FMT: begin
				// Whole-track write; sector pulses only restart the gap fill
				if (idx_edge) begin
					next_l.wg   = 1'b0;
					next_l.gap  = 1'b0;
					next_l.gcnt = '0;
					next_l.ack  = ~l.ack;
					next_l.st   = dgc_pkg::LS_IDLE;
				end else if (sec_edge) begin
					next_l.gap  = 1'b1;
					next_l.gcnt = half_load(GAP_BYTES, 0);
				end
			end
			default: begin
				next_l.st = dgc_pkg::LS_IDLE;
			end
		endcase
		if (!l.rs2) begin
			next_l          = '0;
			next_l.rs1      = RST_N_I;
			next_l.rs2      = l.rs1;
			next_l.req1     = c.req;
			next_l.op       = dgc_pkg::DGC_OP_READ;
			next_l.st       = dgc_pkg::LS_IDLE;
		end
	end

	always_ff @(posedge LINK_CLK_I) begin
		l <= next_l;
	end

	// Outputs straight from the state flops
	assign BUSY_O       = c.busy;
	assign DONE_O       = c.done;
	assign READ_GATE_O  = l.rg;
	assign WRITE_GATE_O = l.wg;
	assign GAP_FILL_O   = l.gap;

	sequence s_lead_gate_rd;
		##1 (!l.rg) [*6] ##1 l.rg;
	endsequence

	sequence s_lead_gate_wr;
		##1 (!l.wg) [*6] ##1 l.wg;
	endsequence

	a_sector_read_lead: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_WAIT && l.op != dgc_pkg::DGC_OP_FORMAT && sec_edge)
		|-> s_lead_gate_rd)
		else $error("read gate not 3.5 bits after sector pulse");

	a_format_wg_lead: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_WAIT && l.op == dgc_pkg::DGC_OP_FORMAT && idx_edge)
		|-> s_lead_gate_wr)
		else $error("format write gate not 3.5 bits after index");

	a_format_wg_hold: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_FMT && sec_edge && !idx_edge) |=> l.wg)
		else $error("format write gate dropped at sector pulse");

	a_format_wg_end: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_FMT && idx_edge) |=> (!l.wg && l.st == dgc_pkg::LS_IDLE))
		else $error("format write gate not ended at index");

	a_no_wg_id_gap: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_POST || l.st == dgc_pkg::LS_HDR) |-> !l.wg)
		else $error("write gate toggled between ID and data");

	a_splice_wg_rise: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		($rose(l.wg) && l.op == dgc_pkg::DGC_OP_WRITE)
		|-> $past(l.st) == dgc_pkg::LS_SPLICE && $past(l.st, 7) == dgc_pkg::LS_POST)
		else $error("write gate not 3 bits into the splice byte");

	a_no_rg_splice: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		(l.st == dgc_pkg::LS_POST || l.st == dgc_pkg::LS_SPLICE) |-> !l.rg)
		else $error("read gate inside the write splice");

	a_gap_under_wg: assert property (@(posedge LINK_CLK_I) disable iff (!l.rs2)
		l.gap |-> (l.wg && l.op == dgc_pkg::DGC_OP_FORMAT))
		else $error("gap fill outside format write gate");

	a_cmd_accept: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(CMD_START_I && !c.busy) |=> (c.busy && c.op == $past(CMD_OP_I)))
		else $error("command not accepted");

endmodule // dgc_gate_seq

/* File: dv/dgc_drive_model.sv */
// Purpose: Drive side of the data cable plus the glue in front of the sequencer
// Assumes: Drive pulses are asynchronous to the core clock and last four link cycles
// Notes:   Servo clock runs free; the read clock takes over the link while reading
`timescale 1ns/1ps
module dgc_drive_model #(
	parameter int unsigned GAP_CYC   = 8,  // Post-index gap added by the glue, servo cycles
	parameter int unsigned LOCK_CYC  = 6,  // Worst-case lock time of the read clock
	parameter int unsigned PULSE_CYC = 4   // Width of a delayed pulse, servo cycles
) (
	input  logic READ_GATE_I,
	input  logic WRITE_GATE_I,
	output logic LINK_CLK_O,
	output logic INDEX_O,
	output logic SECTOR_O,
	output logic ENC_WG_O
);
	logic       servo_write_clock    = 1'b0;
	logic       drive_read_clock     = 1'b0;
	logic       clock_select_request = 1'b0;
	logic       first_stage          = 1'b0;
	logic       select_enable_first  = 1'b0;
	logic       second_stage         = 1'b1;
	logic       select_enable_second = 1'b1;
	logic [7:0] lock_cnt             = 8'h00;
	logic       raw_index            = 1'b0;
	logic       raw_sector           = 1'b0;
	logic       raw_index_q          = 1'b0;
	logic       raw_sector_q         = 1'b0;
	logic [7:0] index_cnt            = 8'h00;
	logic [7:0] sector_cnt           = 8'h00;

	// Two free 15 ns clocks, out of phase with each other and with the core clock
	initial begin
		#3.1;
		forever #7.5 servo_write_clock = ~servo_write_clock;
	end

	initial begin
		#8.3;
		forever #7.5 drive_read_clock = ~drive_read_clock;
	end

	// Read gate held back by the lock time; a falling gate clears the count at once
	always @(posedge servo_write_clock) begin
		if (READ_GATE_I !== 1'b1) begin
			lock_cnt             <= 8'h00;
			clock_select_request <= 1'b0;
		end else if (lock_cnt >= 8'(LOCK_CYC)) begin
			clock_select_request <= 1'b1;
		end else begin
			lock_cnt <= lock_cnt + 8'h01;
		end
	end

	// Each enable waits until the other side is off and moves only while its own clock
	// is low, so no link pulse is cut short; two stages a side set the switch latency
	always @(negedge drive_read_clock) begin
		first_stage         <= clock_select_request & ~select_enable_second;
		select_enable_first <= first_stage;
	end

	always @(negedge servo_write_clock) begin
		second_stage         <= ~clock_select_request & ~select_enable_first;
		select_enable_second <= second_stage;
	end

	// One line carries whichever clock is enabled
	assign LINK_CLK_O = (drive_read_clock & select_enable_first) |
	                    (servo_write_clock & select_enable_second);

	// Each drive pulse is delayed by the gap count; a new pulse reloads its counter,
	// so a pulse that arrives before the previous delayed pulse has left replaces it
	always @(posedge servo_write_clock) begin
		raw_index_q <= raw_index;
		if (raw_index && !raw_index_q) begin
			index_cnt <= 8'(GAP_CYC + PULSE_CYC);
		end else if (index_cnt != 8'h00) begin
			index_cnt <= index_cnt - 8'h01;
		end
	end

	always @(posedge servo_write_clock) begin
		raw_sector_q <= raw_sector;
		if (raw_sector && !raw_sector_q) begin
			sector_cnt <= 8'(GAP_CYC + PULSE_CYC);
		end else if (sector_cnt != 8'h00) begin
			sector_cnt <= sector_cnt - 8'h01;
		end
	end

	// Delayed pulses as the sequencer sees them
	assign INDEX_O  = (index_cnt != 8'h00) && (index_cnt <= 8'(PULSE_CYC));
	assign SECTOR_O = (sector_cnt != 8'h00) && (sector_cnt <= 8'(PULSE_CYC));

	// Encoder gate gets an edge per sector although the sequencer holds its gate up
	assign ENC_WG_O = WRITE_GATE_I & ~SECTOR_O;

	// Held four cycles so the delay counter cannot miss it
	task automatic pulse(input bit sec);
		@(posedge LINK_CLK_O);
		#1;
		if (sec) raw_sector = 1'b1;
		else raw_index = 1'b1;
		repeat (4) @(posedge LINK_CLK_O);
		#1;
		raw_sector = 1'b0;
		raw_index  = 1'b0;
	endtask
endmodule // dgc_drive_model

/* File: dv/test_dgc_gate_seq.sv */
// Purpose: Self-checking bench for the gate sequencer: read, write and format
// Assumes: Small field parameters keep the run short; durations in link cycles
// Notes:   Lead times carry a window because the synchroniser phase varies
`timescale 1ns/1ps
module test_dgc_gate_seq;
	localparam int unsigned HB = 2;
	localparam int unsigned PB = 3;
	localparam int unsigned DB = 4;
	localparam int unsigned GB = 2;
	localparam int unsigned B  = dgc_pkg::HALF_PER_BYTE;
	localparam int unsigned GAP_CYC = 8;            // Post-index gap in the glue
	localparam int unsigned DLY = GAP_CYC + 1;      // Extra link cycles a pulse takes
	logic             core_clk, rst_n, start, link_clk, index, sector;
	logic             busy, done, rg, wg, gap, enc_wg;
	dgc_pkg::dgc_op_e op;
	int               err_count, samples_checked;

	dgc_drive_model #(.GAP_CYC(GAP_CYC)) drv (
		.READ_GATE_I(rg), .WRITE_GATE_I(wg), .LINK_CLK_O(link_clk),
		.INDEX_O(index), .SECTOR_O(sector), .ENC_WG_O(enc_wg));
	dgc_gate_seq #(.HDR_BYTES(HB), .PRE_BYTES(PB), .DATA_BYTES(DB), .GAP_BYTES(GB)) uut (
		.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .LINK_CLK_I(link_clk),
		.CMD_START_I(start), .CMD_OP_I(op), .INDEX_I(index), .SECTOR_I(sector),
		.BUSY_O(busy), .DONE_O(done), .READ_GATE_O(rg), .WRITE_GATE_O(wg),
		.GAP_FILL_O(gap));

	// Core clock, 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic complete_run;
		$display("Checks %0d, errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_cnt(input string what, input int exp, input int seen);
		samples_checked++;
		if (exp != seen) begin
			err_count++;
			$display("Error %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic seen);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask

	function automatic logic pick(input int sel);
		return (sel == 0) ? rg : ((sel == 1) ? wg : gap);
	endfunction

	// Link cycles until the chosen gate reaches lvl; a runaway ends the run
	task automatic wait_lvl(input int sel, input logic lvl, output int n);
		n = 0;
		while (pick(sel) !== lvl) begin
			@(posedge link_clk);
			#1;
			n++;
			if (n > 5000) begin
				err_count++;
				$display("Error gate %0d expected %b seen timeout", sel, lvl);
				complete_run();
			end
		end
	endtask

	task automatic pulse_start(input dgc_pkg::dgc_op_e o);
		@(posedge core_clk);
		#1;
		start = 1'b1;
		op    = o;
		@(posedge core_clk);
		#1;
		start = 1'b0;
	endtask

	task automatic wait_done;
		int k;
		k = 0;
		while (done !== 1'b1) begin
			@(posedge core_clk);
			#1;
			k++;
			if (k > 2000) begin
				err_count++;
				$display("Error done expected 1 seen timeout");
				complete_run();
			end
		end
		chk_bit("busy at done", 1'b0, busy);
	endtask

	task automatic read_sector;
		int n;
		pulse_start(dgc_pkg::DGC_OP_READ);
		chk_bit("busy", 1'b1, busy);
		fork drv.pulse(1'b1); wait_lvl(0, 1'b1, n); join
		chk_bit("read lead", 1'b1, n >= 9 + DLY && n <= 12 + DLY);
		wait_lvl(0, 1'b0, n);
		chk_cnt("read id gate", HB * B, n);
		wait_lvl(0, 1'b1, n);
		chk_cnt("read splice gap", 3 * B, n);
		wait_lvl(0, 1'b0, n);
		chk_cnt("read data gate", (PB - 1 + DB) * B, n);
		chk_bit("read clock on link", 1'b1, drv.select_enable_first);
		chk_bit("wg in read", 1'b0, wg);
		wait_done();
		chk_bit("servo clock on link", 1'b1, drv.select_enable_second);
	endtask

	// A second start while busy must be ignored, so write timing stays
	task automatic write_sector;
		int n;
		pulse_start(dgc_pkg::DGC_OP_WRITE);
		pulse_start(dgc_pkg::DGC_OP_FORMAT);
		fork drv.pulse(1'b0); wait_lvl(0, 1'b1, n); join
		wait_lvl(0, 1'b0, n);
		chk_cnt("write id gate", HB * B, n);
		wait_lvl(1, 1'b1, n);
		chk_cnt("wg delay", 2 * B + 6, n);
		wait_lvl(1, 1'b0, n);
		chk_cnt("wg length", (PB + DB) * B - 6, n);
		wait_done();
	endtask

	task automatic format_track;
		int n;
		pulse_start(dgc_pkg::DGC_OP_FORMAT);
		drv.pulse(1'b1);
		repeat (12) @(posedge link_clk);
		#1;
		chk_bit("wg on sector", 1'b0, wg);
		fork drv.pulse(1'b0); wait_lvl(1, 1'b1, n); join
		chk_bit("format lead", 1'b1, n >= 9 + DLY && n <= 12 + DLY);
		wait_lvl(2, 1'b0, n);
		chk_cnt("gap after index", GB * B, n);
		fork drv.pulse(1'b1); wait_lvl(2, 1'b1, n); join
		chk_bit("encoder gate at sector", 1'b0, enc_wg);
		wait_lvl(2, 1'b0, n);
		chk_cnt("gap after sector", GB * B, n);
		chk_bit("wg over sector", 1'b1, wg);
		repeat (200) @(posedge link_clk);
		#1;
		chk_bit("wg mid track", 1'b1, wg);
		chk_bit("encoder gate mid track", 1'b1, enc_wg);
		fork drv.pulse(1'b0); wait_lvl(1, 1'b0, n); join
		chk_bit("wg drop at index", 1'b1, n >= 3 + DLY && n <= 12 + DLY);
		wait_done();
	endtask

	// Main sequence
	initial begin
		err_count       = 0;
		samples_checked = 0;
		rst_n           = 1'b0;
		start           = 1'b0;
		op              = dgc_pkg::DGC_OP_READ;
		repeat (12) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		chk_bit("busy after reset", 1'b0, busy);
		chk_bit("servo enable at power on", 1'b1, drv.select_enable_second);
		read_sector();
		write_sector();
		format_track();
		complete_run();
	end
endmodule // test_dgc_gate_seq
